// File: rtl/epi_pkg.sv
`default_nettype none
package epi_pkg;
  localparam int NPINS = 8;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_SENSE_LO = 8'h00;
  localparam logic [7:0] OFS_SENSE_HI = 8'h04;
  localparam logic [7:0] OFS_MASK     = 8'h08;
  localparam logic [7:0] OFS_PEND     = 8'h0c;
  localparam logic [7:0] OFS_CTRL     = 8'h10;
  localparam logic [7:0] RST_SENSE_LO = 8'h00;
  localparam logic [7:0] RST_SENSE_HI = 8'h00;
  localparam logic [7:0] RST_MASK     = 8'h00;
  localparam logic [7:0] RST_PEND     = 8'h00;
  localparam logic       RST_GIE      = 1'b0;
  localparam int CTRL_GIE_BIT = 0;
  localparam int ASYNC_PINS = 4;

  typedef enum logic [1:0] {
    SENSE_LOW  = 2'b00,
    SENSE_ANY  = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } epi_sense_t;

  typedef enum logic [2:0] {
    WK_IDLE = 3'b001,
    WK_ONE  = 3'b010,
    WK_DONE = 3'b100
  } epi_wake_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } epi_apb_req_t;
endpackage
`default_nettype wire

// File: rtl/epi_pin_irq.sv
// The register addresses and register access over APB were chosen for this implementation.
`default_nettype none
// Operation
// - pins raise interrupts regardless of their direction, allowing software interrupts.
// - an enabled low-level pin requests the interrupt for as long as it stays low, except while power_down is high.
// - pins 4-7 edges need the gated clock; levels and pins 0-3 edges do not.
// - power-down wake from level needs two low watchdog samples.
// - wake still happens if the level vanishes afterwards, but then no interrupt.
// - pins 0-3 sense codes: low, reserved, falling edge, rising edge.
// - pins 4-7 sense codes: low, any change, falling edge, rising edge.
// - all pins are sampled first; pulses over one clock are caught.
// - a pin interrupt needs both its mask bit and the global enable.
// - changing a sense field while enabled may give a spurious request.
// - a detected edge or change sets the pin flag and requests its vector.
// - flag clears on vector acknowledge or on writing one; zero is ignored.
// - a pin in level mode always reads its flag as zero.
// - sleeping with pins 0-3 disabled turns their input buffers off.
// - legacy mode locks the low-group sense register at its low-level reset.
module epi_pin_irq #(
  parameter int NPINS = epi_pkg::NPINS
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 clk_en,
  input  wire epi_pkg::epi_apb_req_t apb_req,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [NPINS-1:0]     irq_pins,
  input  wire logic [NPINS-1:0]     irq_ack,
  input  wire logic                 sleep_active,
  input  wire logic                 power_down,
  input  wire logic                 wdt_tick,
  input  wire logic                 legacy_mode,
  output logic [NPINS-1:0]          irq_req,
  output logic                      irq,
  output logic [epi_pkg::ASYNC_PINS-1:0] buf_en,
  output logic                      wake_req
);
  import epi_pkg::*;

  logic [7:0]       sense_lo_reg;
  logic [7:0]       sense_hi_reg;
  logic [NPINS-1:0] mask_reg;
  logic [NPINS-1:0] pend_reg;
  logic             gie_reg;
  logic [31:0]      prdata_reg;
  logic [NPINS-1:0] pin_s1_reg;
  logic [NPINS-1:0] pin_s2_reg;
  logic [NPINS-1:0] hist_reg;
  logic [1:0]       legacy_sync_reg;
  epi_wake_t        wk_reg;
  epi_wake_t        wk_next;

  // bus decode
  wire        setup_ph  = apb_req.psel & ~apb_req.penable;
  wire        access_ph = apb_req.psel & apb_req.penable & clk_en;
  wire        wr_en     = access_ph & apb_req.pwrite;
  wire        legacy    = legacy_sync_reg[1];
  wire        hit_lo    = apb_req.paddr == OFS_SENSE_LO;
  wire        hit_hi    = apb_req.paddr == OFS_SENSE_HI;
  wire        hit_mask  = apb_req.paddr == OFS_MASK;
  wire        hit_pend  = apb_req.paddr == OFS_PEND;
  wire        hit_ctrl  = apb_req.paddr == OFS_CTRL;
  wire        hit_any   = hit_lo | hit_hi | hit_mask | hit_pend | hit_ctrl;
  wire        wr_lo     = wr_en & hit_lo & ~legacy;
  wire        wr_hi     = wr_en & hit_hi;
  wire        wr_mask   = wr_en & hit_mask;
  wire        wr_pend   = wr_en & hit_pend;
  wire        wr_ctrl   = wr_en & hit_ctrl;
  wire [15:0] sense_all = {sense_hi_reg, legacy ? RST_SENSE_LO : sense_lo_reg};
  wire [NPINS-1:0] w1c  = wr_pend ? apb_req.pwdata[NPINS-1:0] : '0;

  wire [31:0] rd_mux =
      hit_lo   ? {24'h000000, legacy ? 8'h00 : sense_lo_reg} :
      hit_hi   ? {24'h000000, sense_hi_reg} :
      hit_mask ? {24'h000000, mask_reg} :
      hit_pend ? {24'h000000, pend_reg} :
      hit_ctrl ? {31'h00000000, gie_reg} : 32'h00000000;

  // stalling the bus keeps writes from being lost while the clock is frozen
  assign pready  = clk_en;
  assign pslverr = access_ph & ~hit_any;
  assign prdata  = prdata_reg;

  logic [NPINS-1:0] cur;
  logic [NPINS-1:0] ev_set;
  logic [NPINS-1:0] lvl_mode;
  logic [NPINS-1:0] lvl_low;
  logic [NPINS-1:0] upd_en;
  logic [NPINS-1:0] pend_next;
  logic [NPINS-1:0] hist_next;
  wire  [NPINS-1:0] pin_en = mask_reg & {NPINS{gie_reg}};

  genvar i;
  generate
    for (i = 0; i < NPINS; i++) begin : g_pin
      wire [1:0] sense = sense_all[2*i +: 2];
      wire       fall  = hist_reg[i] & ~cur[i];
      wire       rise  = ~hist_reg[i] & cur[i];
      if (i < ASYNC_PINS) begin : g_async
        // buffer off reads low, which can itself look like an edge
        assign buf_en[i] = ~(sleep_active & ~pin_en[i]);
        assign cur[i]    = buf_en[i] & pin_s2_reg[i];
        // runs without the gated clock so it can wake from sleep
        assign upd_en[i] = 1'b1;
        assign ev_set[i] = (sense == SENSE_FALL) ? fall :
                           (sense == SENSE_RISE) ? rise : 1'b0;
      end else begin : g_sync
        assign cur[i]    = pin_s2_reg[i];
        assign upd_en[i] = clk_en;
        // compares successive samples, so one-clock pulses suffice
        assign ev_set[i] = clk_en & (
                           (sense == SENSE_ANY)  ? (fall | rise) :
                           (sense == SENSE_FALL) ? fall :
                           (sense == SENSE_RISE) ? rise : 1'b0);
      end
      assign lvl_mode[i] = sense == SENSE_LOW;
      assign lvl_low[i]  = lvl_mode[i] & ~cur[i];
      // history is kept across sense changes, hence possible spurious edges
      assign hist_next[i] = upd_en[i] ? cur[i] : hist_reg[i];
      // set beats clear in the same cycle
      // high group flags hold still while the clock is stopped
      assign pend_next[i] = lvl_mode[i] ? 1'b0 :
                            ev_set[i] ? 1'b1 :
                            ~upd_en[i] ? pend_reg[i] :
                            (pend_reg[i] & ~w1c[i] & ~irq_ack[i]);
      // level request is live; no flag, so a vanished level gives none
      assign irq_req[i] = pin_en[i] & (pend_reg[i] | (lvl_low[i] & ~power_down));
    end
  endgenerate

  assign irq = |irq_req;

  // pins sampled as inputs whatever their direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // idle-high reset matches the history, so no false edge after reset
      pin_s1_reg      <= '1;
      pin_s2_reg      <= '1;
      legacy_sync_reg <= 2'b00;
    end else begin
      pin_s1_reg      <= irq_pins;
      pin_s2_reg      <= pin_s1_reg;
      legacy_sync_reg <= {legacy_sync_reg[0], legacy_mode};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_reg <= '1;
      pend_reg <= RST_PEND;
    end else begin
      hist_reg <= hist_next;
      pend_reg <= pend_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_lo_reg <= RST_SENSE_LO;
      sense_hi_reg <= RST_SENSE_HI;
      mask_reg     <= RST_MASK;
      gie_reg      <= RST_GIE;
      prdata_reg   <= 32'h00000000;
    end else if (clk_en) begin
      if (wr_lo) sense_lo_reg <= apb_req.pwdata[7:0];
      if (wr_hi) sense_hi_reg <= apb_req.pwdata[7:0];
      if (wr_mask) mask_reg <= apb_req.pwdata[NPINS-1:0];
      if (wr_ctrl) gie_reg <= apb_req.pwdata[CTRL_GIE_BIT];
      if (setup_ph) prdata_reg <= rd_mux;
    end
  end

  // level wake: two consecutive watchdog samples must see an armed low pin
  wire lvl_wake_src = power_down & |(lvl_low & pin_en);
  always_comb begin
    wk_next = wk_reg;
    unique case (wk_reg)
      WK_IDLE: if (wdt_tick && lvl_wake_src) wk_next = WK_ONE;
      WK_ONE:  if (wdt_tick) wk_next = lvl_wake_src ? WK_DONE : WK_IDLE;
      WK_DONE: if (!power_down) wk_next = WK_IDLE;
      default: wk_next = WK_IDLE;
    endcase
    if (!power_down && wk_reg != WK_DONE) wk_next = WK_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wk_reg <= WK_IDLE;
    else          wk_reg <= wk_next;
  end

  assign wake_req = (wk_reg == WK_DONE) | (sleep_active & |(pend_reg[ASYNC_PINS-1:0] & pin_en[ASYNC_PINS-1:0]));

  a_level_flag_zero: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> ((pend_reg & $past(lvl_mode)) == '0))
    else $error("flag set while pin in level mode");

  a_level_req_held: assert property (@(posedge pclk) disable iff (!presetn)
    (gie_reg && mask_reg[5] && lvl_low[5] && !power_down) [*2] |-> irq)
    else $error("level request dropped while pin low");

  a_both_enables: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> (gie_reg && (mask_reg != '0)))
    else $error("interrupt without enables");

  a_fall_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (sense_all[1:0] == SENSE_FALL && hist_reg[0] && !cur[0]) |=> pend_reg[0])
    else $error("falling edge on pin 0 missed");

  a_reserved_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (sense_all[1:0] == SENSE_ANY && !pend_reg[0]) |=> !pend_reg[0])
    else $error("reserved code set pin 0 flag");

  a_any_change_hi: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && sense_all[9:8] == SENSE_ANY && hist_reg[4] != cur[4]) |=> pend_reg[4])
    else $error("change on pin 4 missed");

  a_w1c_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_pend && apb_req.pwdata[1] && !ev_set[1]) |=> !pend_reg[1])
    else $error("write one did not clear flag");

  a_ack_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_ack[6] && !ev_set[6] && clk_en) |=> !pend_reg[6])
    else $error("acknowledge did not clear flag");

  a_legacy_locked: assert property (@(posedge pclk) disable iff (!presetn)
    (legacy && wr_en && hit_lo) |=> $stable(sense_lo_reg))
    else $error("low sense register written in legacy mode");

  a_hi_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    (!clk_en) |=> $stable(pend_reg[NPINS-1:ASYNC_PINS]))
    else $error("high group flags moved without clock");

  a_wake_two: assert property (@(posedge pclk) disable iff (!presetn)
    (wk_reg == WK_ONE && wdt_tick && lvl_wake_src) |=> wake_req [*2])
    else $error("wake not raised after two samples");

  a_buf_off: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_active && !pin_en[0]) |-> !buf_en[0] ##1 (!sleep_active || !pin_en[0] || buf_en[0]))
    else $error("pin 0 buffer on in sleep while disabled");

  a_irq_is_or: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |irq_req)
    else $error("irq differs from request vector");

  a_req_needs_gie: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_req != '0) |-> gie_reg)
    else $error("request without global enable");

  a_req_needs_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_req & ~mask_reg) == '0)
    else $error("request on masked pin");

  a_pend_raises: assert property (@(posedge pclk) disable iff (!presetn)
    ((pin_en & pend_reg) != '0) |-> irq)
    else $error("enabled flag without interrupt");

  a_req_flag_hi: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_en[7] && pend_reg[7]) |-> irq_req[7])
    else $error("pin 7 flag gave no request");

  a_level_low_req: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_en[4] && lvl_low[4] && !power_down) |-> irq_req[4])
    else $error("low level on pin 4 gave no request");

  a_rise_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (sense_all[3:2] == SENSE_RISE && !hist_reg[1] && cur[1]) |=> pend_reg[1])
    else $error("rising edge on pin 1 missed");

  a_fall_hi_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && sense_all[11:10] == SENSE_FALL && hist_reg[5] && !cur[5]) |=> pend_reg[5])
    else $error("falling edge on pin 5 missed");

  a_rise_hi_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && sense_all[15:14] == SENSE_RISE && !hist_reg[7] && cur[7]) |=> pend_reg[7])
    else $error("rising edge on pin 7 missed");

  a_reserved_no_req: assert property (@(posedge pclk) disable iff (!presetn)
    (sense_all[5:4] == SENSE_ANY && !pend_reg[2]) |-> !irq_req[2])
    else $error("reserved code requested on pin 2");

  a_level_flag_hi: assert property (@(posedge pclk) disable iff (!presetn)
    (sense_all[13:12] == SENSE_LOW) |=> !pend_reg[6])
    else $error("pin 6 flag set in level mode");

  a_pd_level_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (power_down && !pend_reg[3]) |-> !irq_req[3])
    else $error("level request during power-down");

  a_zero_write_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_pend && !apb_req.pwdata[2] && pend_reg[2] && !irq_ack[2] && !lvl_mode[2]) |=> pend_reg[2])
    else $error("writing zero cleared a flag");

  a_ack_async_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_ack[0] && !ev_set[0]) |=> !pend_reg[0])
    else $error("acknowledge did not clear pin 0 flag");

  a_sync_first: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |=> pin_s1_reg == $past(irq_pins))
    else $error("pin not sampled");

  a_sync_chain: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |=> pin_s2_reg == $past(pin_s1_reg))
    else $error("second sample stage broken");

  a_hi_hist_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    (!clk_en) |=> $stable(hist_reg[NPINS-1:ASYNC_PINS]))
    else $error("high group history moved without clock");

  a_hi_no_event: assert property (@(posedge pclk) disable iff (!presetn)
    (!clk_en) |-> (ev_set[NPINS-1:ASYNC_PINS] == '0))
    else $error("high group event without clock");

  a_lo_runs_free: assert property (@(posedge pclk) disable iff (!presetn)
    (!clk_en && sense_all[1:0] == SENSE_FALL && hist_reg[0] && !cur[0]) |=> pend_reg[0])
    else $error("pin 0 edge lost while clock stopped");

  a_wake_first: assert property (@(posedge pclk) disable iff (!presetn)
    (wk_reg == WK_IDLE && wdt_tick && lvl_wake_src) |=> wk_reg == WK_ONE)
    else $error("first wake sample not taken");

  a_wake_no_src: assert property (@(posedge pclk) disable iff (!presetn)
    (wk_reg == WK_IDLE && !lvl_wake_src) |=> wk_reg == WK_IDLE)
    else $error("wake sampling without source");

  a_wake_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (wk_reg == WK_ONE && wdt_tick && !lvl_wake_src) |=> wk_reg == WK_IDLE)
    else $error("wake kept after failed sample");

  a_wake_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot(wk_reg))
    else $error("wake state not one-hot");

  a_wake_leaves: assert property (@(posedge pclk) disable iff (!presetn)
    (wk_reg == WK_DONE && !power_down) |=> wk_reg == WK_IDLE)
    else $error("wake state kept after power-down");

  a_edge_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_active && pend_reg[0] && pin_en[0]) |-> wake_req)
    else $error("edge flag did not wake");

  a_buf_awake: assert property (@(posedge pclk) disable iff (!presetn)
    (!sleep_active) |-> (buf_en == '1))
    else $error("buffer off while awake");

  a_buf_enabled: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_active && pin_en[1]) |-> buf_en[1])
    else $error("enabled pin 1 buffer off in sleep");

  a_legacy_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (legacy && setup_ph && clk_en && hit_lo) |=> (prdata == 32'h00000000))
    else $error("low sense register readable in legacy mode");

  a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_mask |=> mask_reg == $past(apb_req.pwdata[NPINS-1:0]))
    else $error("mask write lost");

  a_gie_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> gie_reg == $past(apb_req.pwdata[CTRL_GIE_BIT]))
    else $error("global enable write lost");

  a_sense_hi_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_hi |=> sense_hi_reg == $past(apb_req.pwdata[7:0]))
    else $error("high sense write lost");
endmodule
`default_nettype wire

// File: verif/epi_pin_drv.sv
`default_nettype none
module epi_pin_drv (
  input  wire logic       pclk,
  input  wire logic [7:0] pin_want,
  output logic      [7:0] irq_pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // each level is held for many cycles, far beyond one instruction
  always @(posedge pclk) irq_pins <= pin_want;
endmodule
`default_nettype wire

// File: verif/tb_external_pin_interrupt_unit.sv
`default_nettype none
module tb_external_pin_interrupt_unit;
  import epi_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic                 pclk = 1'b0;
  logic                 presetn = 1'b0;
  logic                 clk_en = 1'b1;
  epi_apb_req_t         apb_req = '0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic [7:0]           irq_pins;
  logic [7:0]           pin_want = 8'hff;
  logic [7:0]           irq_ack = 8'h00;
  logic                 sleep_active = 1'b0;
  logic                 power_down = 1'b0;
  logic                 wdt_tick = 1'b0;
  logic                 legacy_mode = 1'b0;
  logic [7:0]           irq_req;
  logic                 irq;
  logic [3:0]           buf_en;
  logic                 wake_req;
  logic [31:0]          rdv;
  logic                 errv;
  logic [7:0]           o_v, n_v, ev;
  logic [1:0]           code;
  int                   num_errors = 0;
  int                   n_checks = 0;
  int                   seed = 73;
  always #2.5 pclk = ~pclk;
  epi_pin_drv drv (.pclk(pclk), .pin_want(pin_want), .irq_pins(irq_pins));
  epi_pin_irq dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_pins(irq_pins), .irq_ack(irq_ack), .sleep_active(sleep_active),
    .power_down(power_down), .wdt_tick(wdt_tick), .legacy_mode(legacy_mode), .irq_req(irq_req), .irq(irq),
    .buf_en(buf_en), .wake_req(wake_req));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk) apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk) apb_req.penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      num_errors++;
      report_and_stop();
    end
    rdv = prdata;
    errv = pslverr;
    apb_req <= '0;
  endtask
  // expected flags after the pins move from o to n under one sense code
  function automatic logic [7:0] expf(logic [1:0] c, logic [7:0] o, logic [7:0] n);
    for (int i = 0; i < 8; i++) begin
      case (c)
        2'b01:   expf[i] = (i >= ASYNC_PINS) && (o[i] != n[i]);
        2'b10:   expf[i] = o[i] & ~n[i];
        2'b11:   expf[i] = ~o[i] & n[i];
        default: expf[i] = 1'b0;
      endcase
    end
  endfunction
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_MASK, 32'h0);
    chk(rdv, {24'h0, RST_MASK});
    apb(1'b0, OFS_PEND, 32'h0);
    chk(rdv, {24'h0, RST_PEND});
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, errv}, 32'h1);
    sleep_active <= 1'b1;
    @(posedge pclk);
    @(negedge pclk) chk({28'h0, buf_en}, 32'h0);
    @(posedge pclk) sleep_active <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_MASK, 32'hff);
    for (int c = 0; c < 4; c++) begin
      for (int t = 0; t < 5; t++) begin
        code = c[1:0];
        o_v = $random(seed);
        n_v = $random(seed);
        pin_want <= o_v;
        apb(1'b1, OFS_MASK, 32'h0);
        apb(1'b1, OFS_SENSE_LO, {24'h0, {4{code}}});
        apb(1'b1, OFS_SENSE_HI, {24'h0, {4{code}}});
        repeat (6) @(posedge pclk);
        apb(1'b1, OFS_PEND, 32'hff);
        apb(1'b1, OFS_MASK, 32'hff);
        pin_want <= n_v;
        repeat (6) @(posedge pclk);
        apb(1'b0, OFS_PEND, 32'h0);
        ev = expf(code, o_v, n_v);
        chk(rdv, {24'h0, ev});
        if (code == 2'b00) begin
          ev = ~n_v;
          chk({24'h0, irq_req}, {24'h0, ev});
        end else begin
          chk({31'h0, irq}, {31'h0, |ev});
          apb(1'b1, OFS_PEND, 32'h0);
          apb(1'b0, OFS_PEND, 32'h0);
          chk(rdv, {24'h0, ev});
          irq_ack <= ev;
          @(posedge pclk) irq_ack <= 8'h00;
          apb(1'b0, OFS_PEND, 32'h0);
          chk(rdv, 32'h0);
        end
      end
    end
    pin_want <= 8'h00;
    repeat (6) @(posedge pclk);
    apb(1'b1, OFS_CTRL, 32'h0);
    pin_want <= 8'hff;
    repeat (6) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1);
    @(negedge pclk);
    chk({24'h0, irq_req}, 32'hff);
    apb(1'b1, OFS_SENSE_LO, 32'h0);
    apb(1'b1, OFS_PEND, 32'hff);
    power_down <= 1'b1;
    pin_want <= 8'hfe;
    repeat (6) @(posedge pclk);
    chk({31'h0, wake_req}, 32'h0);
    repeat (2) begin
      wdt_tick <= 1'b1;
      @(posedge pclk) wdt_tick <= 1'b0;
      @(posedge pclk);
    end
    chk({31'h0, wake_req}, 32'h1);
    power_down <= 1'b0;
    legacy_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, OFS_SENSE_LO, 32'hff);
    apb(1'b0, OFS_SENSE_LO, 32'h0);
    chk(rdv, 32'h0);
    pin_want <= 8'h0f;
    repeat (6) @(posedge pclk);
    apb(1'b1, OFS_PEND, 32'hff);
    clk_en <= 1'b0;
    pin_want <= 8'hff;
    repeat (6) @(posedge pclk);
    chk({24'h0, irq_req}, 32'h0);
    clk_en <= 1'b1;
    repeat (6) @(posedge pclk);
    chk({24'h0, irq_req}, 32'hf0);
    report_and_stop();
  end
endmodule
`default_nettype wire
